// ==== rtl/vbus_ctrl_pkg.sv ====
package vbus_ctrl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NS_PER_MS = 1000000;
  localparam int unsigned ADC_W = 10;
  localparam int unsigned LSB_MV = 25;
  localparam int unsigned TMR_W = 23;
  // longest time: rounds down
  localparam int unsigned DISC_DETECT_MS = 6;
  localparam int unsigned DISC_DETECT_CYC = DISC_DETECT_MS * NS_PER_MS / CLK_PERIOD_NS;
  // least time before a fault: rounds up
  localparam int unsigned SAFE0V_MS = 650;
  localparam int unsigned SAFE0V_CYC = (SAFE0V_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDOG_MS = 40;
  localparam int unsigned WDOG_CYC = WDOG_MS * NS_PER_MS / CLK_PERIOD_NS;
  // upper edge of the 5 V band, in ADC codes
  localparam int unsigned VSAFE5V_MV = 5500;
  localparam logic [ADC_W-1:0] VSAFE5V_CODE = ADC_W'(VSAFE5V_MV / LSB_MV);
  localparam logic [1:0] CC_OPEN = 2'h0;
  localparam logic [3:0] ROLE_DISABLE = 4'hF;
  localparam logic SINK_ROLE = 1'h0;
  localparam int unsigned PWR_SNK_BIT = 0;
  localparam int unsigned PWR_SRC_BIT = 1;
  localparam int unsigned PWR_VBUS_BIT = 2;
  localparam int unsigned PWR_DISCH_BIT = 3;
  localparam logic [7:0] PWR_RESET = 8'h00;
  localparam int unsigned THR_LO = 0;
  localparam int unsigned THR_HI = 1;
  localparam int unsigned THR_SNK = 2;
  localparam int unsigned THR_STOP = 3;
  localparam int unsigned THR_5V = 4;
  localparam int unsigned THR_N = 5;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WATCH = 4'h2,
    ST_CONFIRM = 4'h4,
    ST_DISCH = 4'h8
  } disch_state_type;
endpackage : vbus_ctrl_pkg

// ==== rtl/vbus_timer.sv ====
`timescale 1ns/10ps
module vbus_timer (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic i_run,
  input wire logic [vbus_ctrl_pkg::TMR_W-1:0] i_count,
  output logic o_done
);
  typedef struct packed {
    logic [vbus_ctrl_pkg::TMR_W-1:0] cnt;
    logic active;
    logic done;
  } timer_state_type;
  timer_state_type q, d;

  always_comb begin
    d = q;
    d.done = 1'h0;
    if (i_load) begin
      d.cnt = i_count;
      d.active = 1'h1;
    end else if (!i_run) begin
      d.active = 1'h0;
    end else if (q.active) begin
      if (q.cnt <= vbus_ctrl_pkg::TMR_W'(1)) begin
        d.done = 1'h1;
        d.active = 1'h0;
      end else begin
        d.cnt = q.cnt - vbus_ctrl_pkg::TMR_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_done = q.done;
endmodule : vbus_timer

// ==== rtl/vbus_threshold_cmp.sv ====
`timescale 1ns/10ps
module vbus_threshold_cmp (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire logic [vbus_ctrl_pkg::ADC_W-1:0] i_sample,
  input wire logic [vbus_ctrl_pkg::THR_N*vbus_ctrl_pkg::ADC_W-1:0] i_thr,
  output logic o_valid,
  output logic [vbus_ctrl_pkg::THR_N-1:0] o_above,
  output logic [vbus_ctrl_pkg::THR_N-1:0] o_below
);
  typedef struct packed {
    logic valid;
    logic [vbus_ctrl_pkg::THR_N-1:0] above;
    logic [vbus_ctrl_pkg::THR_N-1:0] below;
  } cmp_state_type;
  cmp_state_type q, d;
  logic [vbus_ctrl_pkg::THR_N-1:0] gt;
  logic [vbus_ctrl_pkg::THR_N-1:0] lt;

  // one comparator pair per threshold
  for (genvar i = 0; i < vbus_ctrl_pkg::THR_N; i++) begin : g_cmp
    assign gt[i] = i_sample > i_thr[i*vbus_ctrl_pkg::ADC_W +: vbus_ctrl_pkg::ADC_W];
    assign lt[i] = i_sample < i_thr[i*vbus_ctrl_pkg::ADC_W +: vbus_ctrl_pkg::ADC_W];
  end

  always_comb begin
    d = q;
    d.valid = i_valid;
    if (i_valid) begin
      d.above = gt;
      d.below = lt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_valid = q.valid;
  assign o_above = q.above;
  assign o_below = q.below;
endmodule : vbus_threshold_cmp

// ==== rtl/vbus_monitor_discharge_ctrl.sv ====
// Function
// - flag VBUS presence in power status and pulse power-changed on any status change.
// - publish every ADC sample as a low/high pair, 25 mV per LSB.
// - pulse low or high alarm when a sample crosses its threshold.
// - alarm-disable bit suppresses both voltage alarm pulses.
// - port-power alert is any bit of status AND mask.
// - bleed-enable drives bleed load, force-discharge drives full load.
// - source mode while source path on; auto discharge then runs on disconnect.
// - source disconnect when selected CC pin reads open; then full discharge.
// - sink mode whenever the header power-role bit is zero.
// - sink above 5 V uses sink threshold; at 5 V uses presence loss.
// - sink auto mode bleeds until below threshold, disconnect within 6 ms, then full.
// - CC terminations stay removed after disconnect until VBUS reaches safe zero.
// - automatic discharge switches off once VBUS is below safe zero.
// - no safe zero within 650 ms: fault pulse, timeout flag, discharge stays on.
// - manual force discharge ends when sample reaches stop threshold.
// - watchdog runs only while its enable bit is one.
// - watchdog starts on alert or interrupt pin, restarts on host access.
// - watchdog expiry forces role bits 1111, paths off, discharge, link-error flag.
// - source and sink paths switch off autonomously on detach.
`timescale 1ns/10ps
module vbus_monitor_discharge_ctrl #(
  parameter int unsigned DISC_DETECT_CYC = vbus_ctrl_pkg::DISC_DETECT_CYC,
  parameter int unsigned SAFE0V_CYC = vbus_ctrl_pkg::SAFE0V_CYC,
  parameter int unsigned WDOG_CYC = vbus_ctrl_pkg::WDOG_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_vbus_present,
  input wire logic i_vbus_below_safe0v,
  input wire logic i_adc_valid,
  input wire logic [vbus_ctrl_pkg::ADC_W-1:0] i_adc_data,
  input wire logic [vbus_ctrl_pkg::ADC_W-1:0] i_low_alarm_threshold,
  input wire logic [vbus_ctrl_pkg::ADC_W-1:0] i_high_alarm_threshold,
  input wire logic [vbus_ctrl_pkg::ADC_W-1:0] i_sink_disconnect_threshold,
  input wire logic [vbus_ctrl_pkg::ADC_W-1:0] i_discharge_stop_threshold,
  input wire logic [7:0] i_power_status_mask_reg,
  input wire logic i_alarm_disable_bit,
  input wire logic i_bleed_load_enable,
  input wire logic i_full_load_enable,
  input wire logic i_automatic_discharge_enable,
  input wire logic i_plug_orientation_select,
  input wire logic [1:0] i_cc1_pin_state_field,
  input wire logic [1:0] i_cc2_pin_state_field,
  input wire logic i_power_role,
  input wire logic i_src_path_on,
  input wire logic i_src_path_off,
  input wire logic i_snk_path_on,
  input wire logic i_snk_path_off,
  input wire logic i_watchdog_enable,
  input wire logic i_alert_unmasked_any,
  input wire logic i_host_interrupt_pin,
  input wire logic i_host_access,
  input wire logic i_fault_clear,
  output logic o_vbus_present_flag,
  output logic [7:0] o_power_status_reg,
  output logic o_power_status_changed,
  output logic o_port_power_alert,
  output logic [7:0] o_vbus_measure_low,
  output logic [7:0] o_vbus_measure_high,
  output logic o_high_voltage_alarm_irq,
  output logic o_low_voltage_alarm_irq,
  output logic o_bleed_load,
  output logic o_full_discharge_load,
  output logic o_src_path,
  output logic o_snk_path,
  output logic o_cc_term_removed,
  output logic o_disconnect,
  output logic o_role_control_load,
  output logic [3:0] o_role_control_value,
  output logic o_fault_irq,
  output logic o_discharge_timeout_flag,
  output logic o_host_link_error_flag
);
  typedef struct packed {
    vbus_ctrl_pkg::disch_state_type st;
    logic present;
    logic [7:0] pwr_stat;
    logic pwr_chg;
    logic alert;
    logic [vbus_ctrl_pkg::ADC_W-1:0] meas;
    logic hi_seen;
    logic lo_seen;
    logic hi_irq;
    logic lo_irq;
    logic hv;
    logic forced;
    logic bleed;
    logic full;
    logic src;
    logic snk;
    logic term_off;
    logic disc;
    logic role_ld;
    logic fault_irq;
    logic tmo_flag;
    logic link_err;
    logic wd_run;
  } ctrl_state_type;

  ctrl_state_type q, d;
  logic cmp_valid;
  logic [vbus_ctrl_pkg::THR_N-1:0] above;
  logic [vbus_ctrl_pkg::THR_N-1:0] below;
  logic [vbus_ctrl_pkg::THR_N*vbus_ctrl_pkg::ADC_W-1:0] thr_vec;
  logic confirm_done;
  logic safe0_done;
  logic wd_done;
  logic confirm_load;
  logic safe0_load;
  logic wd_load;
  logic wd_arm;
  logic cc_sel;
  logic sink_mode;
  logic src_disc;

  assign thr_vec = {vbus_ctrl_pkg::VSAFE5V_CODE, i_discharge_stop_threshold, i_sink_disconnect_threshold,
                    i_high_alarm_threshold, i_low_alarm_threshold};

  vbus_threshold_cmp u_cmp (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_valid(i_adc_valid),
    .i_sample(i_adc_data),
    .i_thr(thr_vec),
    .o_valid(cmp_valid),
    .o_above(above),
    .o_below(below)
  );

  vbus_timer u_confirm_tmr (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_load(confirm_load),
    .i_run(q.st == vbus_ctrl_pkg::ST_CONFIRM),
    .i_count(vbus_ctrl_pkg::TMR_W'(DISC_DETECT_CYC)),
    .o_done(confirm_done)
  );

  vbus_timer u_safe0_tmr (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_load(safe0_load),
    .i_run(q.st == vbus_ctrl_pkg::ST_DISCH),
    .i_count(vbus_ctrl_pkg::TMR_W'(SAFE0V_CYC)),
    .o_done(safe0_done)
  );

  vbus_timer u_wdog_tmr (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_load(wd_load),
    .i_run(q.wd_run),
    .i_count(vbus_ctrl_pkg::TMR_W'(WDOG_CYC)),
    .o_done(wd_done)
  );

  assign cc_sel = i_plug_orientation_select ? (i_cc2_pin_state_field == vbus_ctrl_pkg::CC_OPEN)
                                            : (i_cc1_pin_state_field == vbus_ctrl_pkg::CC_OPEN);
  assign sink_mode = i_power_role == vbus_ctrl_pkg::SINK_ROLE;
  assign src_disc = i_automatic_discharge_enable && q.src && cc_sel;
  // watchdog armed by any pending alert or the interrupt pin
  assign wd_arm = i_watchdog_enable && (i_alert_unmasked_any || i_host_interrupt_pin);
  assign wd_load = wd_arm && (!q.wd_run || i_host_access);
  assign confirm_load = d.st == vbus_ctrl_pkg::ST_CONFIRM && q.st != vbus_ctrl_pkg::ST_CONFIRM;
  assign safe0_load = d.st == vbus_ctrl_pkg::ST_DISCH && q.st != vbus_ctrl_pkg::ST_DISCH;

  always_comb begin
    d = q;
    d.disc = 1'h0;
    d.role_ld = 1'h0;
    d.fault_irq = 1'h0;
    d.hi_irq = 1'h0;
    d.lo_irq = 1'h0;
    d.present = i_vbus_present;
    if (i_adc_valid) begin
      d.meas = i_adc_data;
    end
    if (cmp_valid) begin
      d.hv = above[vbus_ctrl_pkg::THR_5V];
      d.hi_seen = above[vbus_ctrl_pkg::THR_HI];
      d.lo_seen = below[vbus_ctrl_pkg::THR_LO];
      // pulse only on the sample that crosses
      d.hi_irq = above[vbus_ctrl_pkg::THR_HI] && !q.hi_seen && !i_alarm_disable_bit;
      d.lo_irq = below[vbus_ctrl_pkg::THR_LO] && !q.lo_seen && !i_alarm_disable_bit;
    end
    if (i_src_path_on) begin
      d.src = 1'h1;
    end else if (i_src_path_off) begin
      d.src = 1'h0;
    end
    if (i_snk_path_on) begin
      d.snk = 1'h1;
    end else if (i_snk_path_off) begin
      d.snk = 1'h0;
    end
    if (i_full_load_enable) begin
      d.forced = 1'h1;
    end else if (cmp_valid && !above[vbus_ctrl_pkg::THR_STOP]) begin
      d.forced = 1'h0;
    end
    if (!i_full_load_enable && q.forced && cmp_valid && !above[vbus_ctrl_pkg::THR_STOP]) begin
      d.forced = 1'h0;
    end
    case (q.st)
      vbus_ctrl_pkg::ST_IDLE: begin
        if (src_disc) begin
          d.st = vbus_ctrl_pkg::ST_DISCH;
          d.disc = 1'h1;
        end else if (i_automatic_discharge_enable && sink_mode && q.snk) begin
          d.st = vbus_ctrl_pkg::ST_WATCH;
        end
      end
      vbus_ctrl_pkg::ST_WATCH: begin
        if (src_disc) begin
          d.st = vbus_ctrl_pkg::ST_DISCH;
          d.disc = 1'h1;
        end else if (!i_automatic_discharge_enable || !sink_mode) begin
          d.st = vbus_ctrl_pkg::ST_IDLE;
        end else if (q.hv && cmp_valid && below[vbus_ctrl_pkg::THR_SNK]) begin
          d.st = vbus_ctrl_pkg::ST_CONFIRM;
        end else if (!q.hv && q.present && !i_vbus_present) begin
          d.st = vbus_ctrl_pkg::ST_DISCH;
          d.disc = 1'h1;
        end
      end
      vbus_ctrl_pkg::ST_CONFIRM: begin
        if (!i_automatic_discharge_enable || !sink_mode) begin
          d.st = vbus_ctrl_pkg::ST_IDLE;
        end else if (confirm_done || (cmp_valid && below[vbus_ctrl_pkg::THR_SNK])) begin
          d.st = vbus_ctrl_pkg::ST_DISCH;
          d.disc = 1'h1;
        end else if (cmp_valid) begin
          d.st = vbus_ctrl_pkg::ST_WATCH;
        end
      end
      vbus_ctrl_pkg::ST_DISCH: begin
        if (i_vbus_below_safe0v) begin
          d.st = vbus_ctrl_pkg::ST_IDLE;
        end else if (safe0_done) begin
          d.fault_irq = 1'h1;
        end
      end
      default: begin
        d.st = vbus_ctrl_pkg::ST_IDLE;
      end
    endcase
    d.wd_run = wd_arm;
    if (wd_done) begin
      d.role_ld = 1'h1;
      d.link_err = 1'h1;
      d.st = vbus_ctrl_pkg::ST_DISCH;
      d.disc = 1'h1;
    end else if (i_fault_clear) begin
      d.link_err = 1'h0;
    end
    if (d.fault_irq) begin
      d.tmo_flag = 1'h1;
    end else if (i_fault_clear) begin
      d.tmo_flag = 1'h0;
    end
    if (d.disc) begin
      d.src = 1'h0;
      d.snk = 1'h0;
    end
    d.term_off = d.st == vbus_ctrl_pkg::ST_DISCH;
    d.full = d.forced || d.st == vbus_ctrl_pkg::ST_DISCH;
    d.bleed = i_bleed_load_enable || (d.st == vbus_ctrl_pkg::ST_WATCH && d.hv);
    d.pwr_stat = vbus_ctrl_pkg::PWR_RESET;
    d.pwr_stat[vbus_ctrl_pkg::PWR_SNK_BIT] = d.snk;
    d.pwr_stat[vbus_ctrl_pkg::PWR_SRC_BIT] = d.src;
    d.pwr_stat[vbus_ctrl_pkg::PWR_VBUS_BIT] = d.present;
    d.pwr_stat[vbus_ctrl_pkg::PWR_DISCH_BIT] = d.full;
    d.pwr_chg = d.pwr_stat != q.pwr_stat;
    d.alert = |(d.pwr_stat & i_power_status_mask_reg);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q <= '0;
      q.st <= vbus_ctrl_pkg::ST_IDLE;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_vbus_present_flag = q.present;
  assign o_power_status_reg = q.pwr_stat;
  assign o_power_status_changed = q.pwr_chg;
  assign o_port_power_alert = q.alert;
  assign o_vbus_measure_low = q.meas[7:0];
  assign o_vbus_measure_high = {6'h00, q.meas[vbus_ctrl_pkg::ADC_W-1:8]};
  assign o_high_voltage_alarm_irq = q.hi_irq;
  assign o_low_voltage_alarm_irq = q.lo_irq;
  assign o_bleed_load = q.bleed;
  assign o_full_discharge_load = q.full;
  assign o_src_path = q.src;
  assign o_snk_path = q.snk;
  assign o_cc_term_removed = q.term_off;
  assign o_disconnect = q.disc;
  assign o_role_control_load = q.role_ld;
  assign o_role_control_value = vbus_ctrl_pkg::ROLE_DISABLE;
  assign o_fault_irq = q.fault_irq;
  assign o_discharge_timeout_flag = q.tmo_flag;
  assign o_host_link_error_flag = q.link_err;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  chk_alert_and: assert property ($past(i_ce) |->
    o_port_power_alert == |(o_power_status_reg & $past(i_power_status_mask_reg)))
    else $error("port power alert disagrees with status and mask");
  chk_measure_pub: assert property (i_ce && i_adc_valid |=>
    {o_vbus_measure_high[1:0], o_vbus_measure_low} == $past(i_adc_data))
    else $error("sample not published");
  chk_alarm_off: assert property (i_ce && i_alarm_disable_bit |=>
    !o_high_voltage_alarm_irq && !o_low_voltage_alarm_irq)
    else $error("alarm fired while disabled");
  chk_src_disc: assert property (i_ce && q.st == vbus_ctrl_pkg::ST_IDLE && src_disc && !wd_done |=>
    o_full_discharge_load && o_cc_term_removed && !o_src_path && o_disconnect)
    else $error("source disconnect not acted on");
  chk_term_hold: assert property (q.st == vbus_ctrl_pkg::ST_DISCH |->
    o_cc_term_removed && o_full_discharge_load)
    else $error("terminations back during discharge");
  chk_safe0_end: assert property (i_ce && q.st == vbus_ctrl_pkg::ST_DISCH && i_vbus_below_safe0v && !wd_done
    |=> q.st == vbus_ctrl_pkg::ST_IDLE && !o_cc_term_removed)
    else $error("discharge not ended at safe zero");
  chk_fault_keep: assert property ($rose(o_discharge_timeout_flag) |->
    o_full_discharge_load && o_fault_irq)
    else $error("timeout without discharge held");
  chk_wdog_fire: assert property (i_ce && wd_done |=>
    o_role_control_load && o_role_control_value == 4'hF && !o_src_path && !o_snk_path
    && o_host_link_error_flag && o_full_discharge_load)
    else $error("watchdog expiry incomplete");
  chk_wdog_idle: assert property (!i_watchdog_enable && i_ce |=> !q.wd_run)
    else $error("watchdog running while disabled");
  chk_confirm_go: assert property (i_ce && q.st == vbus_ctrl_pkg::ST_CONFIRM && i_automatic_discharge_enable
    && sink_mode && confirm_done |=> q.st == vbus_ctrl_pkg::ST_DISCH)
    else $error("sink disconnect not declared at deadline");

  cov_src_disc: cover property (q.st == vbus_ctrl_pkg::ST_IDLE ##1 q.st == vbus_ctrl_pkg::ST_DISCH);
  cov_sink_confirm: cover property (q.st == vbus_ctrl_pkg::ST_CONFIRM ##1 q.st == vbus_ctrl_pkg::ST_DISCH);
  cov_timeout: cover property ($rose(o_discharge_timeout_flag));
  cov_wdog: cover property (o_role_control_load);
endmodule : vbus_monitor_discharge_ctrl

// ==== verif/vbus_sense_model.sv ====
`timescale 1ns/10ps
module vbus_sense_model #(
  parameter int unsigned PERIOD = 8,
  parameter int unsigned PRESENT_CODE = 160,
  parameter int unsigned SAFE0_CODE = 32
) (
  input wire logic i_clk,
  input wire logic [vbus_ctrl_pkg::ADC_W-1:0] i_code,
  output logic o_adc_valid,
  output logic [vbus_ctrl_pkg::ADC_W-1:0] o_adc_data,
  output logic o_vbus_present,
  output logic o_below_safe0v
);
  int unsigned cnt;
  always @(posedge i_clk) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    o_adc_valid <= (cnt == 0);
    // data is scrambled outside the valid pulse
    o_adc_data <= (cnt == 0) ? i_code : ~i_code;
    o_vbus_present <= (i_code >= 10'(PRESENT_CODE));
    o_below_safe0v <= (i_code < 10'(SAFE0_CODE));
  end
endmodule : vbus_sense_model

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic i_clk, i_srst, ce, auto, plug_orientation_select, role, wd_en, pin, alrt, dis, bleed, full;
  logic [9:0] code;
  logic [1:0] cc1, cc2;
  // pulses: 0 src on, 1 fault clear, 2 snk on, 3 host access, 4 src off, 5 snk off
  logic [5:0] pls;
  logic [7:0] mask;
  logic adc_v, pres, safe0;
  logic [9:0] adc_d;
  logic pflag, pchg, palert, hia, loa, bl, fl, srcp, snkp, term, disc, rload, firq, tflag, lflag;
  logic [7:0] pstat, mlo, mhi;
  logic [3:0] rval;
  logic [4:0] expq[$];
  int err_count, total_checks;

  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  vbus_sense_model i_adc (.i_clk(i_clk), .i_code(code), .o_adc_valid(adc_v), .o_adc_data(adc_d),
    .o_vbus_present(pres), .o_below_safe0v(safe0));

  vbus_monitor_discharge_ctrl #(.DISC_DETECT_CYC(20), .SAFE0V_CYC(50), .WDOG_CYC(30)) i_dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(ce), .i_vbus_present(pres), .i_vbus_below_safe0v(safe0),
    .i_adc_valid(adc_v), .i_adc_data(adc_d), .i_low_alarm_threshold(10'h064),
    .i_high_alarm_threshold(10'h190), .i_sink_disconnect_threshold(10'h0C8),
    .i_discharge_stop_threshold(10'h078), .i_power_status_mask_reg(mask), .i_alarm_disable_bit(dis),
    .i_bleed_load_enable(bleed), .i_full_load_enable(full), .i_automatic_discharge_enable(auto),
    .i_plug_orientation_select(plug_orientation_select), .i_cc1_pin_state_field(cc1), .i_cc2_pin_state_field(cc2),
    .i_power_role(role), .i_src_path_on(pls[0]), .i_src_path_off(pls[4]), .i_snk_path_on(pls[2]),
    .i_snk_path_off(pls[5]), .i_watchdog_enable(wd_en), .i_alert_unmasked_any(alrt),
    .i_host_interrupt_pin(pin), .i_host_access(pls[3]), .i_fault_clear(pls[1]), .o_vbus_present_flag(pflag),
    .o_power_status_reg(pstat), .o_power_status_changed(pchg), .o_port_power_alert(palert),
    .o_vbus_measure_low(mlo), .o_vbus_measure_high(mhi), .o_high_voltage_alarm_irq(hia),
    .o_low_voltage_alarm_irq(loa), .o_bleed_load(bl), .o_full_discharge_load(fl), .o_src_path(srcp),
    .o_snk_path(snkp), .o_cc_term_removed(term), .o_disconnect(disc), .o_role_control_load(rload),
    .o_role_control_value(rval), .o_fault_irq(firq), .o_discharge_timeout_flag(tflag),
    .o_host_link_error_flag(lflag));

  task automatic cmp_lvl(input logic [15:0] act, input logic [15:0] exp);
    total_checks++;
    if (act !== exp) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : cmp_lvl

  task automatic cmp_evt(input logic [4:0] act);
    logic [4:0] exp;
    exp = (expq.size() > 0) ? expq.pop_front() : 5'h00;
    total_checks++;
    if (act !== exp) begin
      err_count++;
      $display("BAD event t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : cmp_evt

  // pulse events: {role load, fault, disconnect, low alarm, high alarm}
  always @(negedge i_clk) begin
    if (!i_srst && (rload | firq | disc | loa | hia) !== 1'h0)
      cmp_evt({rload, firq, disc, loa, hia});
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  task automatic wait_empty(input int n);
    for (int i = 0; i < n && expq.size() > 0; i++) @(posedge i_clk);
    cyc(2);
    if (expq.size() > 0) begin
      cmp_lvl(16'(expq.size()), 16'h0000);
      expq.delete();
    end
  endtask : wait_empty

  task automatic pulse(input int b);
    @(posedge i_clk) pls <= 6'(1 << b);
    @(posedge i_clk) pls <= 6'h00;
  endtask : pulse

  task automatic set_code(input logic [9:0] c, input int n);
    @(posedge i_clk) code <= c;
    cyc(n);
  endtask : set_code

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  initial begin
    cyc(20000);
    err_count++;
    finish_test();
  end

  initial begin
    logic [9:0] r;
    {auto, plug_orientation_select, role, wd_en, pin, alrt, bleed, full} = '0;
    pls = 6'h00;
    ce = 1'h1;
    cc2 = 2'h0;
    i_srst = 1'h1;
    dis = 1'h1;
    role = 1'h1;
    code = 10'h0C8;
    cc1 = 2'h2;
    mask = 8'h00;
    void'($urandom(32'h02dc0883));
    cyc(3);
    i_srst <= 1'h0;
    cyc(1);
    cmp_lvl({pstat, bl, fl, tflag, lflag, rval}, {8'h00, 4'h0, 4'hF});
    for (int k = 0; k < 4; k++) begin
      r = 10'($urandom());
      set_code(r, 20);
      cmp_lvl({mhi, mlo}, {6'h00, r});
    end
    set_code(10'h0C8, 20);
    mask <= 8'h04;
    cyc(3);
    cmp_lvl({pflag, pstat[2], palert}, 3'h7);
    mask <= 8'h00;
    cyc(3);
    cmp_lvl(palert, 1'h0);
    dis <= 1'h0;
    expq.push_back(5'h01);
    set_code(10'h1F4, 0);
    wait_empty(20);
    expq.push_back(5'h02);
    set_code(10'h032, 0);
    wait_empty(20);
    dis <= 1'h1;
    set_code(10'h1F4, 20);
    set_code(10'h0C8, 20);
    // clock enable low freezes the published sample
    ce <= 1'h0;
    set_code(10'h1F4, 20);
    cmp_lvl({mhi, mlo}, 16'h00C8);
    ce <= 1'h1;
    set_code(10'h0C8, 20);
    // source auto discharge, CC2 open but unwatched
    auto <= 1'h1;
    pulse(0);
    cyc(20);
    cmp_lvl({srcp, fl, disc}, 3'h4);
    for (int t = 0; t < 2; t++) begin
      // second pass watches CC2
      if (t == 1) begin
        plug_orientation_select <= 1'h1;
        cc2 <= 2'h2;
        pulse(0);
      end
      expq.push_back(5'h04);
      @(posedge i_clk);
      if (t == 0)
        cc1 <= 2'h0;
      else
        cc2 <= 2'h0;
      wait_empty(5);
      cmp_lvl({fl, term, srcp, snkp}, 4'hC);
      if (t == 1) begin
        expq.push_back(5'h08);
        wait_empty(70);
        cmp_lvl({tflag, fl}, 2'h3);
      end
      set_code(10'h000, 20);
      cmp_lvl({fl, term}, 2'h0);
      pulse(1);
      cc1 <= 2'h2;
      cc2 <= 2'h2;
      set_code(10'h0C8, 20);
    end
    cmp_lvl(tflag, 1'h0);
    // sink auto discharge
    role <= 1'h0;
    set_code(10'h12C, 20);
    pulse(2);
    cyc(20);
    cmp_lvl({snkp, bl}, 2'h3);
    expq.push_back(5'h04);
    set_code(10'h096, 0);
    wait_empty(40);
    cmp_lvl({fl, term, snkp}, 3'h6);
    set_code(10'h000, 20);
    cmp_lvl({fl, term}, 2'h0);
    // sink at 5 V: presence loss is the disconnect
    set_code(10'h0C8, 20);
    pulse(2);
    cyc(20);
    expq.push_back(5'h04);
    set_code(10'h064, 0);
    wait_empty(20);
    cmp_lvl({fl, term, snkp}, 3'h6);
    set_code(10'h000, 20);
    // manual loads, auto cleared first
    auto <= 1'h0;
    set_code(10'h0C8, 20);
    full <= 1'h1;
    bleed <= 1'h1;
    cyc(3);
    cmp_lvl({fl, bl}, 2'h3);
    full <= 1'h0;
    bleed <= 1'h0;
    cyc(20);
    cmp_lvl({fl, bl}, 2'h2);
    set_code(10'h06E, 20);
    cmp_lvl(fl, 1'h0);
    // watchdog
    role <= 1'h1;
    set_code(10'h0C8, 10);
    pulse(0);
    pin <= 1'h1;
    cyc(60);
    wd_en <= 1'h1;
    alrt <= 1'h1;
    repeat (6) begin
      cyc(10);
      pulse(3);
    end
    expq.push_back(5'h14);
    wait_empty(40);
    cmp_lvl({lflag, srcp, snkp, fl, rval}, {4'h9, 4'hF});
    {wd_en, pin, alrt} <= 3'h0;
    set_code(10'h000, 20);
    pulse(1);
    cyc(3);
    cmp_lvl({lflag, fl}, 2'h0);
    // path on and off pulses, power-changed pulse
    pulse(0);
    pulse(2);
    cyc(2);
    cmp_lvl({srcp, snkp}, 2'h3);
    pulse(4);
    pulse(5);
    cyc(1);
    cmp_lvl({pchg, srcp, snkp}, 3'h4);
    cyc(1);
    cmp_lvl(pchg, 1'h0);
    finish_test();
  end
endmodule : tb_top
